// *** lpc_logical_device_decoder.sv ***
// LPC target engine and logical-device address decoder
`timescale 1ns/1ns
module lpc_logical_device_decoder
  import lpc_dec_pkg::*;
(
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // bus pins
  input wire logic BUS_RESET_N,
  input wire logic LFRAME_N,
  input wire logic [3:0] LAD_IN,
  output logic [3:0] LAD_OUT,
  output logic LAD_OE_N,
  output logic LDRQ_N,
  // power event pin, open drain
  input wire logic PME_REQ,
  output logic POWER_EVENT_OUT_N,
  output logic POWER_EVENT_OE_N,
  // logical-device side
  output logic [15:0] DEV_SEL,
  output logic DEV_WIN2,
  output logic [6:0] DEV_OFFSET,
  output logic DEV_WR,
  output logic [7:0] DEV_WDATA,
  input wire logic [7:0] DEV_RDATA,
  input wire logic DEV_READY,
  // dma side
  output logic DMA_STB,
  output logic [2:0] DMA_CHAN
);
  typedef struct packed {
    lpc_state_e st;
    logic [1:0] cnt;
    logic is_dma;
    logic is_write;
    logic second;
    logic [15:0] addr;
    logic [7:0] data;
    logic [3:0] lad_out;
    logic lad_oe_n;
    logic ldrq_n;
    logic pme_oe_n;
    logic [15:0] sel;
    logic [15:0] hit_sel;
    logic win2;
    logic [6:0] offset;
    logic dev_wr;
    logic dma_stb;
    logic [2:0] chan;
    logic cfg_acc;
    logic [7:0] cfg_index;
    logic [3:0] ldn;
    logic [15:0] cfg_base;
    logic [15:0][15:0] base1;
    logic [15:0] base2;
    logic [15:0] act;
  } state_s;

  state_s s_reg;
  state_s s_next;
  logic bus_rst_n_q;
  logic [3:0] lad_q;
  logic fr_n;
  logic rst_i;
  logic host_data;
  logic [15:0] win_hit;
  logic [15:0][6:0] win_off;
  logic key_hit;
  logic [6:0] key_off;
  logic [15:0] dec_sel;
  logic [6:0] dec_off;
  logic dec_win2;
  logic dec_cfg;
  logic claim;
  logic [7:0] cfg_rd;

  // ---------------------------------------------------------------
  // pin synchronisers and reset
  // ---------------------------------------------------------------
  // only bus reset is asynchronous; frame and nibbles are clocked by the bus clock
  // itself and a one-clock nibble would never pass the agreement filter
  lpc_pin_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .CE(CE),
    .d(BUS_RESET_N),
    .q(bus_rst_n_q)
  );
  assign lad_q = LAD_IN;
  assign fr_n = LFRAME_N;
  assign rst_i = RST || !bus_rst_n_q;
  assign host_data = s_reg.is_dma ? !s_reg.is_write : s_reg.is_write;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one base window per logical device that has one
  for (genvar i = 0; i < LDN_COUNT; i++)
  begin : g_win
    if (WIN_LOG2[i] != 4'h0)
    begin : g_on
      lpc_window_match #(.SIZE_LOG2(int'(WIN_LOG2[i]))) u_win (
        .en(s_reg.act[i]),
        .base(s_reg.base1[i]),
        .addr(s_reg.addr),
        .hit(win_hit[i]),
        .offset(win_off[i])
      );
    end
    else
    begin : g_off
      assign win_hit[i] = 1'b0;
      assign win_off[i] = 7'h00;
    end
  end

  // second window of the runtime device
  lpc_window_match #(.SIZE_LOG2(KEY_WIN_LOG2)) u_key (
    .en(s_reg.act[LDN_RUNTIME]),
    .base(s_reg.base2),
    .addr(s_reg.addr),
    .hit(key_hit),
    .offset(key_off)
  );

  // pick at most one target: base windows lowest device number first, then keyboard ports, then key window
  always_comb
  begin
    dec_sel = 16'h0000;
    dec_off = 7'h00;
    dec_win2 = 1'b0;
    dec_cfg = (s_reg.addr == s_reg.cfg_base) || (s_reg.addr == s_reg.cfg_base + 16'h0001);
    for (int i = 0; i < LDN_COUNT; i++)
    begin
      if (win_hit[i] && dec_sel == 16'h0000 && !(i == 0 && win_off[i] == FLOPPY_HOLE))
      begin
        dec_sel[i] = 1'b1;
        dec_off = win_off[i];
      end
    end
    if (dec_sel == 16'h0000 && s_reg.act[LDN_KBD]
        && (s_reg.addr == KBD_PORT_DATA || s_reg.addr == KBD_PORT_CMD))
    begin
      dec_sel[LDN_KBD] = 1'b1;
      dec_off = {4'h0, s_reg.addr[2], 2'h0};
    end
    if (dec_sel == 16'h0000 && key_hit)
    begin
      dec_sel[LDN_RUNTIME] = 1'b1;
      dec_off = key_off;
      dec_win2 = 1'b1;
    end
    if (dec_cfg)
    begin
      dec_sel = 16'h0000;
    end
    claim = dec_cfg || (dec_sel != 16'h0000);
  end

  // configuration register read-back
  always_comb
  begin
    cfg_rd = 8'h00;
    if (s_reg.addr == s_reg.cfg_base)
    begin
      cfg_rd = s_reg.cfg_index;
    end
    else
    begin
      unique case (s_reg.cfg_index)
        CFG_IDX_LDN: cfg_rd = {4'h0, s_reg.ldn};
        CFG_IDX_BASE_LO: cfg_rd = s_reg.cfg_base[7:0];
        CFG_IDX_BASE_HI: cfg_rd = s_reg.cfg_base[15:8];
        CFG_IDX_ACT: cfg_rd = {7'h00, s_reg.act[s_reg.ldn]};
        CFG_IDX_B1_HI: cfg_rd = s_reg.base1[s_reg.ldn][15:8];
        CFG_IDX_B1_LO: cfg_rd = s_reg.base1[s_reg.ldn][7:0];
        CFG_IDX_B2_HI: cfg_rd = s_reg.base2[15:8];
        CFG_IDX_B2_LO: cfg_rd = s_reg.base2[7:0];
        default: cfg_rd = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus cycle engine
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.sel = 16'h0000;
    s_next.dma_stb = 1'b0;
    s_next.ldrq_n = 1'b1;
    s_next.pme_oe_n = !PME_REQ;
    if (!fr_n)
    begin
      s_next.lad_oe_n = 1'b1;
      s_next.st = (lad_q == START_TARGET) ? ST_CTYPE : ST_IDLE;
    end
    else
    begin
      unique case (s_reg.st)
        ST_IDLE:
        begin
          s_next.lad_oe_n = 1'b1;
        end
        ST_CTYPE:
        begin
          s_next.is_write = lad_q[1];
          s_next.cnt = 2'h0;
          s_next.second = 1'b0;
          s_next.is_dma = (lad_q[3:2] == CYC_DMA);
          if (lad_q[3:2] == CYC_IO)
          begin
            s_next.st = ST_ADDR;
          end
          else if (lad_q[3:2] == CYC_DMA)
          begin
            s_next.st = ST_CHAN;
          end
          else
          begin
            s_next.st = ST_IDLE;
          end
        end
        ST_ADDR:
        begin
          s_next.addr = {s_reg.addr[11:0], lad_q};
          s_next.cnt = s_reg.cnt + 2'h1;
          if (s_reg.cnt == ADDR_LAST)
          begin
            s_next.cnt = 2'h0;
            s_next.st = s_reg.is_write ? ST_WDATA : ST_TAR1;
          end
        end
        ST_CHAN:
        begin
          s_next.chan = lad_q[2:0];
          s_next.st = ST_SIZE;
        end
        ST_SIZE:
        begin
          s_next.second = (lad_q == SIZE_TWO);
          if (lad_q == SIZE_ONE || lad_q == SIZE_TWO)
          begin
            s_next.st = host_data ? ST_WDATA : ST_TAR1;
          end
          else
          begin
            s_next.st = ST_IDLE;
          end
        end
        ST_WDATA:
        begin
          // low nibble first, one byte per pass; a two-byte dma comes back here for its second byte
          s_next.cnt = s_reg.cnt + 2'h1;
          if (s_reg.cnt == 2'h0)
          begin
            s_next.data[3:0] = lad_q;
          end
          else
          begin
            s_next.data[7:4] = lad_q;
            s_next.cnt = 2'h0;
            s_next.st = ST_TAR1;
          end
        end
        ST_TAR1:
        begin
          s_next.hit_sel = dec_sel;
          s_next.offset = dec_off;
          s_next.win2 = dec_win2;
          s_next.cfg_acc = dec_cfg && !s_reg.is_dma;
          s_next.st = (s_reg.is_dma || claim) ? ST_TAR2 : ST_IDLE;
        end
        ST_TAR2:
        begin
          s_next.lad_oe_n = 1'b0;
          s_next.lad_out = s_reg.is_dma ? SYNC_SHORT : SYNC_LONG;
          s_next.st = ST_SYNC;
          s_next.dev_wr = host_data;
          if (s_reg.is_dma)
          begin
            s_next.dma_stb = 1'b1;
          end
          else
          begin
            s_next.sel = s_reg.hit_sel;
          end
          if (s_reg.cfg_acc && host_data)
          begin
            if (s_reg.addr == s_reg.cfg_base)
            begin
              s_next.cfg_index = s_reg.data;
            end
            else
            begin
              unique case (s_reg.cfg_index)
                CFG_IDX_LDN: s_next.ldn = s_reg.data[3:0];
                CFG_IDX_BASE_LO: s_next.cfg_base[7:0] = s_reg.data;
                CFG_IDX_BASE_HI: s_next.cfg_base[15:8] = s_reg.data;
                CFG_IDX_ACT: s_next.act[s_reg.ldn] = s_reg.data[0];
                CFG_IDX_B1_HI: s_next.base1[s_reg.ldn][15:8] = s_reg.data;
                CFG_IDX_B1_LO: s_next.base1[s_reg.ldn][7:0] = s_reg.data;
                CFG_IDX_B2_HI: s_next.base2[15:8] = s_reg.data;
                CFG_IDX_B2_LO: s_next.base2[7:0] = s_reg.data;
                default: s_next.cfg_index = s_reg.cfg_index;
              endcase
            end
          end
        end
        ST_SYNC:
        begin
          if (s_reg.cfg_acc || DEV_READY)
          begin
            s_next.lad_out = SYNC_READY;
            s_next.st = ST_POST;
            if (!host_data)
            begin
              s_next.data = s_reg.cfg_acc ? cfg_rd : DEV_RDATA;
            end
          end
        end
        ST_POST:
        begin
          if (!host_data)
          begin
            s_next.lad_out = s_reg.data[3:0];
            s_next.st = ST_RDATA;
          end
          else if (s_reg.second)
          begin
            s_next.second = 1'b0;
            s_next.lad_oe_n = 1'b1;
            s_next.st = ST_WDATA;
          end
          else
          begin
            s_next.lad_out = TAR_IDLE;
            s_next.st = ST_TARB;
          end
        end
        ST_RDATA:
        begin
          s_next.lad_out = s_reg.data[7:4];
          s_next.st = ST_RDONE;
        end
        ST_RDONE:
        begin
          if (s_reg.second)
          begin
            s_next.second = 1'b0;
            s_next.lad_out = SYNC_SHORT;
            s_next.dma_stb = 1'b1;
            s_next.st = ST_SYNC;
          end
          else
          begin
            s_next.lad_out = TAR_IDLE;
            s_next.st = ST_TARB;
          end
        end
        ST_TARB:
        begin
          s_next.lad_oe_n = 1'b1;
          s_next.st = ST_IDLE;
        end
      endcase
    end
  end

  // state register; bus reset floats the bus and clears the engine
  always_ff @(posedge CLOCK)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.lad_out <= TAR_IDLE;
      s_reg.lad_oe_n <= 1'b1;
      s_reg.ldrq_n <= 1'b1;
      s_reg.pme_oe_n <= 1'b1;
      s_reg.cfg_base <= CFG_BASE_RESET;
      s_reg.base1 <= BASE1_RESET;
      s_reg.base2 <= BASE2_RESET;
      s_reg.act <= ACT_RESET;
    end
    else if (CE)
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign LAD_OUT = s_reg.lad_out;
  assign LAD_OE_N = s_reg.lad_oe_n;
  assign LDRQ_N = s_reg.ldrq_n;
  assign POWER_EVENT_OUT_N = s_reg.ldrq_n ^ s_reg.ldrq_n;
  assign POWER_EVENT_OE_N = s_reg.pme_oe_n;
  assign DEV_SEL = s_reg.sel;
  assign DEV_WIN2 = s_reg.win2;
  assign DEV_OFFSET = s_reg.offset;
  assign DEV_WR = s_reg.dev_wr;
  assign DEV_WDATA = s_reg.data;
  assign DMA_STB = s_reg.dma_stb;
  assign DMA_CHAN = s_reg.chan;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (rst_i || !CE);

  sequence seq_io_sync_start;
    fr_n && s_reg.st == ST_TAR2 && !s_reg.is_dma;
  endsequence
  sequence seq_cfg_base_write;
    fr_n && s_reg.st == ST_TAR2 && s_reg.cfg_acc && s_reg.is_write
      && s_reg.addr != s_reg.cfg_base && s_reg.cfg_index == CFG_IDX_BASE_LO;
  endsequence

  io_long_wait_a: assert property (seq_io_sync_start |=> !LAD_OE_N && LAD_OUT == SYNC_LONG)
    else $error("io sync did not open with long wait");
  dma_short_wait_a: assert property (fr_n && s_reg.st == ST_TAR2 && s_reg.is_dma |=> LAD_OUT == SYNC_SHORT)
    else $error("dma sync did not open with short wait");
  unclaimed_quiet_a: assert property (fr_n && s_reg.st == ST_TAR1 && !s_reg.is_dma && !claim |=> LAD_OE_N [*3])
    else $error("bus driven for an unclaimed address");
  cfg_relocate_a: assert property (seq_cfg_base_write |=> s_reg.cfg_base[7:0] == $past(s_reg.data))
    else $error("configuration base not moved");
  single_select_a: assert property ($onehot0(DEV_SEL) && !(DEV_SEL != 16'h0000 && DMA_STB))
    else $error("more than one target selected");
  frame_abort_a: assert property (!fr_n |=> LAD_OE_N)
    else $error("bus still driven after frame");
  power_event_a: assert property (PME_REQ |=> !POWER_EVENT_OE_N && !POWER_EVENT_OUT_N)
    else $error("power event not driven low");
  size_ignore_a: assert property (fr_n && s_reg.st == ST_SIZE && lad_q > SIZE_TWO |=> s_reg.st == ST_IDLE)
    else $error("unsupported dma size not ignored");
  bus_reset_float_a: assert property (@(posedge CLOCK) disable iff (1'b0) rst_i |=> LAD_OE_N && LDRQ_N)
    else $error("bus not floated in reset");
endmodule : lpc_logical_device_decoder

// *** lpc_dec_pkg.sv ***
// constants and types of the LPC logical-device decoder
package lpc_dec_pkg;
  localparam int LDN_COUNT = 16;
  // nibble codes on the address/data lines
  localparam logic [3:0] START_TARGET = 4'h0;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] SYNC_SHORT = 4'h5;
  localparam logic [3:0] SYNC_LONG = 4'h6;
  localparam logic [3:0] TAR_IDLE = 4'hf;
  localparam logic [1:0] CYC_IO = 2'h0;
  localparam logic [1:0] CYC_DMA = 2'h2;
  localparam logic [3:0] SIZE_ONE = 4'h0;
  localparam logic [3:0] SIZE_TWO = 4'h1;
  localparam logic [1:0] ADDR_LAST = 2'h3;
  // configuration block: index and data ports, register indices
  localparam logic [15:0] CFG_BASE_RESET = 16'h002e;
  localparam logic [7:0] CFG_IDX_LDN = 8'h07;
  localparam logic [7:0] CFG_IDX_BASE_LO = 8'h26;
  localparam logic [7:0] CFG_IDX_BASE_HI = 8'h27;
  localparam logic [7:0] CFG_IDX_ACT = 8'h30;
  localparam logic [7:0] CFG_IDX_B1_HI = 8'h60;
  localparam logic [7:0] CFG_IDX_B1_LO = 8'h61;
  localparam logic [7:0] CFG_IDX_B2_HI = 8'h62;
  localparam logic [7:0] CFG_IDX_B2_LO = 8'h63;
  // logical devices with special decoding
  localparam logic [3:0] LDN_FLOPPY = 4'h0;
  localparam logic [3:0] LDN_KBD = 4'h7;
  localparam logic [3:0] LDN_RUNTIME = 4'ha;
  localparam logic [6:0] FLOPPY_HOLE = 7'h06;
  localparam logic [15:0] KBD_PORT_DATA = 16'h0060;
  localparam logic [15:0] KBD_PORT_CMD = 16'h0064;
  localparam int KEY_WIN_LOG2 = 5;
  // window size (log2 of ports) per logical device, 0 = no base window
  localparam logic [15:0][3:0] WIN_LOG2 = {4'h0, 4'h3, 4'h3, 4'h3, 4'h3, 4'h7, 4'h0, 4'h0,
                                           4'h0, 4'h0, 4'h3, 4'h3, 4'h3, 4'h0, 4'h0, 4'h3};
  // base addresses and activation after reset
  localparam logic [15:0][15:0] BASE1_RESET = {16'h0000, 16'h02e0, 16'h03e0, 16'h02e8, 16'h03e8,
                                               16'h0a00, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                               16'h02f8, 16'h03f8, 16'h0378, 16'h0000, 16'h0000,
                                               16'h03f0};
  localparam logic [15:0] BASE2_RESET = 16'h0b00;
  localparam logic [15:0] ACT_RESET = 16'h00b1;
  // bus engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_CTYPE, ST_ADDR, ST_CHAN, ST_SIZE, ST_WDATA, ST_TAR1,
    ST_TAR2, ST_SYNC, ST_POST, ST_RDATA, ST_RDONE, ST_TARB
  } lpc_state_e;
endpackage : lpc_dec_pkg

// *** lpc_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lpc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // pins in, filtered level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_s;
  sync_s s_reg;
  sync_s s_next;

  // shift; a bit changes only once stages two and three agree
  always_comb
  begin
    s_next = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s_reg.s2[i] == s_reg.s3[i])
      begin
        s_next.q[i] = s_reg.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      s_reg <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end
    else if (CE)
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;
endmodule : lpc_pin_sync

// *** lpc_window_match.sv ***
// aligned power-of-two address window compare
`timescale 1ns/1ns
module lpc_window_match #(
  parameter int SIZE_LOG2 = 3
) (
  // window setup
  input wire logic en,
  input wire logic [15:0] base,
  // address under test
  input wire logic [15:0] addr,
  output logic hit,
  output logic [6:0] offset
);
  // upper bits select the window, lower bits are the offset
  assign hit = en && (addr[15:SIZE_LOG2] == base[15:SIZE_LOG2]);
  assign offset = 7'(addr[SIZE_LOG2-1:0]);
endmodule : lpc_window_match

// *** lpc_host_model.sv ***
// host chipset model: drives lpc cycles, watches the device's sync and data
`timescale 1ns/1ns
module lpc_host_model
  import lpc_dec_pkg::*;
(
  // clock
  input wire logic CLOCK,
  // bus wires
  output logic LFRAME_N,
  output logic [3:0] LAD_IN,
  input wire logic [3:0] LAD_OUT,
  input wire logic LAD_OE_N
);
  // ----------------------------------------
  // wire level and host cycle tasks
  // ----------------------------------------
  logic [3:0] drv = 4'hf;
  logic [3:0] wait_code;
  logic [7:0] rd_data;
  event rd_done;
  initial LFRAME_N = 1'b1;
  // device drive wins; otherwise the line carries the host's last drv nibble
  assign LAD_IN = (LAD_OE_N === 1'b0) ? LAD_OUT : drv;

  // one nibble per clock, changed just after the falling edge
  task automatic put(input logic fr, input logic [3:0] nb);
    @(negedge CLOCK);
    LFRAME_N = fr;
    drv = nb;
  endtask : put

  // start, header nibbles, turnaround, then wait for the device's sync
  task automatic xfer(input logic [3:0] nib[$], input int nrd, input bit cut, output bit claimed);
    bit ready;
    claimed = 1'b0;
    ready = 1'b0;
    wait_code = 4'h0;
    put(1'b0, START_TARGET);
    foreach (nib[k]) put(1'b1, nib[k]);
    if (cut) return;
    put(1'b1, TAR_IDLE);
    put(1'b1, TAR_IDLE);
    // bounded wait for the ready sync code
    for (int i = 0; i < 40 && !ready; i++)
    begin
      @(negedge CLOCK);
      // a driven cycle that never reaches ready counts as not claimed
      if (LAD_OE_N === 1'b0 && LAD_OUT === SYNC_READY)
      begin
        ready = 1'b1;
        claimed = 1'b1;
      end
      else if (LAD_OE_N === 1'b0) wait_code = LAD_OUT;
    end
    // data byte arrives low nibble first
    if (ready && nrd > 0)
    begin
      @(negedge CLOCK);
      rd_data[3:0] = LAD_OUT;
      @(negedge CLOCK);
      rd_data[7:4] = LAD_OUT;
      -> rd_done;
    end
    repeat (4) @(negedge CLOCK);
  endtask : xfer
endmodule : lpc_host_model

// *** testbench.sv ***
// self-checking testbench of the lpc logical-device decoder
`timescale 1ns/1ns
module testbench
  import lpc_dec_pkg::*;
;
  // ----------------------------------------
  // signals, instances, clock
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] sel;
    logic w2;
    logic dc;
    logic [6:0] off;
    logic wr;
    logic [7:0] wd;
  } sel_s;
  logic CLOCK, RST, CE, BUS_RESET_N, LFRAME_N, LAD_OE_N, LDRQ_N, PME_REQ;
  logic POWER_EVENT_OUT_N, POWER_EVENT_OE_N, DEV_WIN2, DEV_WR, DMA_STB;
  logic DEV_READY = 1'b1;
  logic [3:0] LAD_IN, LAD_OUT;
  logic [15:0] DEV_SEL;
  logic [6:0] DEV_OFFSET;
  logic [7:0] DEV_WDATA, DEV_RDATA, d;
  logic [2:0] DMA_CHAN, ch;
  logic [15:0] cfg_base = CFG_BASE_RESET;
  logic [3:0] n[$];
  logic [3:0] bad_ct[4] = '{4'h4, 4'h6, 4'hc, 4'he};
  sel_s sel_q[$];
  logic [7:0] rd_q[$];
  int num_errors = 0;
  int n_compared = 0;
  int ready_delay = 0;
  int hold_cnt = 0;
  int o;
  bit c;

  lpc_logical_device_decoder i_dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .BUS_RESET_N(BUS_RESET_N),
    .LFRAME_N(LFRAME_N), .LAD_IN(LAD_IN), .LAD_OUT(LAD_OUT), .LAD_OE_N(LAD_OE_N), .LDRQ_N(LDRQ_N),
    .PME_REQ(PME_REQ), .POWER_EVENT_OUT_N(POWER_EVENT_OUT_N), .POWER_EVENT_OE_N(POWER_EVENT_OE_N),
    .DEV_SEL(DEV_SEL), .DEV_WIN2(DEV_WIN2), .DEV_OFFSET(DEV_OFFSET), .DEV_WR(DEV_WR),
    .DEV_WDATA(DEV_WDATA), .DEV_RDATA(DEV_RDATA), .DEV_READY(DEV_READY), .DMA_STB(DMA_STB),
    .DMA_CHAN(DMA_CHAN));
  lpc_host_model i_host (.CLOCK(CLOCK), .LFRAME_N(LFRAME_N), .LAD_IN(LAD_IN), .LAD_OUT(LAD_OUT),
    .LAD_OE_N(LAD_OE_N));

  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  // ----------------------------------------
  // compare tasks and verdict
  // ----------------------------------------
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_sel(input sel_s e);
    logic bad;
    bad = DEV_WR !== e.wr || (e.wr && DEV_WDATA !== e.wd);
    if (e.sel !== 16'h0) bad = bad || DEV_SEL !== e.sel || DEV_WIN2 !== e.w2 || (!e.dc && DEV_OFFSET !== e.off);
    else bad = bad || DMA_CHAN !== e.off[2:0];
    n_compared++;
    if (bad)
    begin
      num_errors++;
      $display("BAD %0t strobe sel %h off %h", $time, DEV_SEL, DEV_OFFSET);
    end
  endtask : cmp_sel

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic print_verdict;
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // watchers and target-side stimulus
  // ----------------------------------------
  // each strobe takes the oldest expectation
  always @(negedge CLOCK)
    if (RST === 1'b0 && (DEV_SEL !== 16'h0 || DMA_STB === 1'b1))
    begin
      if (sel_q.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_sel(sel_q.pop_front());
    end
  always
  begin
    @(i_host.rd_done);
    cmp_rd(i_host.rd_data, rd_q.pop_front());
  end
  // target holds off ready for a while after each strobe
  always @(negedge CLOCK)
  begin
    if (DEV_SEL !== 16'h0 || DMA_STB === 1'b1) hold_cnt = ready_delay;
    else if (hold_cnt > 0) hold_cnt--;
    DEV_READY = (hold_cnt == 0);
  end
  initial
  begin
    repeat (60000) @(negedge CLOCK);
    cmp_bit(1'b0, 1'b1);
    print_verdict();
  end

  // ----------------------------------------
  // bus cycle helpers
  // ----------------------------------------
  task automatic push(input logic [15:0] s, input logic w2, input int off, input logic wr, input logic [7:0] wd);
    sel_q.push_back('{s, w2, off < 0, off[6:0], wr, wd});
  endtask : push

  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] dv, input bit exp);
    logic [3:0] q[$];
    bit cl;
    q = {wr ? 4'h2 : 4'h0, a[15:12], a[11:8], a[7:4], a[3:0]};
    if (wr) q = {q, dv[3:0], dv[7:4]};
    i_host.xfer(q, wr ? 0 : 2, 1'b0, cl);
    cmp_bit(cl, exp);
  endtask : io

  task automatic cfg(input logic [7:0] idx, input logic [7:0] v);
    io(1'b1, cfg_base, idx, 1'b1);
    io(1'b1, cfg_base + 16'h1, v, 1'b1);
  endtask : cfg

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, cfg_base, idx, 1'b1);
    rd_q.push_back(exp);
    io(1'b0, cfg_base + 16'h1, 8'h0, 1'b1);
  endtask : cfg_rd

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(55988));
    RST = 1'b1;
    CE = 1'b1;
    BUS_RESET_N = 1'b1;
    PME_REQ = 1'b0;
    DEV_RDATA = 8'h0;
    repeat (10) @(negedge CLOCK);
    cmp_bit(LAD_OE_N, 1'b1);
    RST = 1'b0;
    repeat (2) @(negedge CLOCK);
    // serial write, then serial read with long waits
    o = $urandom_range(7);
    d = $urandom();
    push(16'h0010, 1'b0, o, 1'b1, d);
    io(1'b1, 16'h03f8 + o[15:0], d, 1'b1);
    DEV_RDATA = $urandom();
    ready_delay = 8;
    push(16'h0020, 1'b0, o, 1'b0, 8'h0);
    rd_q.push_back(DEV_RDATA);
    io(1'b0, 16'h02f8 + o[15:0], 8'h0, 1'b1);
    cmp_bit(i_host.wait_code === SYNC_LONG, 1'b1);
    ready_delay = 0;
    // floppy offsets, hole at 6
    for (int k = 0; k < 8; k++)
    begin
      d = $urandom();
      if (k != 6) push(16'h0001, 1'b0, k, 1'b1, d);
      io(1'b1, 16'h03f0 + k[15:0], d, k != 6);
    end
    // keyboard fixed ports, unclaimed places
    for (int k = 0; k < 2; k++)
    begin
      push(16'h0080, 1'b0, -1, 1'b0, 8'h0);
      rd_q.push_back(DEV_RDATA);
      io(1'b0, KBD_PORT_DATA + 16'h4 * k[15:0], 8'h0, 1'b1);
    end
    io(1'b1, 16'h0378, 8'h1, 1'b0);
    io(1'b0, 16'h0100, 8'h0, 1'b0);
    // relocate and enable parallel block
    cfg(CFG_IDX_LDN, 8'h03);
    cfg(CFG_IDX_ACT, 8'h01);
    cfg(CFG_IDX_B1_HI, 8'h02);
    cfg(CFG_IDX_B1_LO, 8'h78);
    cfg_rd(CFG_IDX_B1_LO, 8'h78);
    push(16'h0008, 1'b0, 2, 1'b1, 8'h5a);
    io(1'b1, 16'h027a, 8'h5a, 1'b1);
    io(1'b1, 16'h037a, 8'h5a, 1'b0);
    // runtime and key windows
    cfg(CFG_IDX_LDN, {4'h0, LDN_RUNTIME});
    cfg(CFG_IDX_ACT, 8'h01);
    push(16'h0400, 1'b0, 127, 1'b1, 8'h11);
    io(1'b1, 16'h0a7f, 8'h11, 1'b1);
    push(16'h0400, 1'b1, 31, 1'b1, 8'h22);
    io(1'b1, 16'h0b1f, 8'h22, 1'b1);
    io(1'b1, 16'h0b20, 8'h33, 1'b0);
    // move the configuration block itself
    cfg(CFG_IDX_BASE_LO, 8'h4e);
    cfg_base = 16'h004e;
    cfg_rd(CFG_IDX_BASE_LO, 8'h4e);
    // refused cycle types and sizes
    foreach (bad_ct[k])
    begin
      n = {bad_ct[k], 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'hf, 4'h8};
      i_host.xfer(n, 2, 1'b0, c);
      cmp_bit(c, 1'b0);
    end
    n = {4'h8, 4'h1, 4'h3, 4'h0, 4'h0};
    i_host.xfer(n, 0, 1'b0, c);
    cmp_bit(c, 1'b0);
    // dma to and from the device with short waits
    ready_delay = 3;
    d = $urandom();
    ch = $urandom_range(7);
    push(16'h0, 1'b0, ch, 1'b1, d);
    n = {4'h8, 4'(ch), SIZE_ONE, d[3:0], d[7:4]};
    i_host.xfer(n, 0, 1'b0, c);
    cmp_bit(c && i_host.wait_code === SYNC_SHORT, 1'b1);
    DEV_RDATA = $urandom();
    push(16'h0, 1'b0, ch, 1'b0, 8'h0);
    rd_q.push_back(DEV_RDATA);
    n = {4'ha, 4'(ch), SIZE_ONE};
    i_host.xfer(n, 2, 1'b0, c);
    cmp_bit(c, 1'b1);
    ready_delay = 0;
    // abort mid-address, next cycle must run
    n = {4'h2, 4'h0, 4'h3};
    i_host.xfer(n, 0, 1'b1, c);
    d = $urandom();
    push(16'h0010, 1'b0, 1, 1'b1, d);
    io(1'b1, 16'h03f9, d, 1'b1);
    // power event
    PME_REQ = 1'b1;
    @(negedge CLOCK);
    cmp_bit(POWER_EVENT_OE_N | POWER_EVENT_OUT_N, 1'b0);
    PME_REQ = 1'b0;
    @(negedge CLOCK);
    cmp_bit(POWER_EVENT_OE_N, 1'b1);
    // bus reset restores the defaults
    BUS_RESET_N = 1'b0;
    repeat (8) @(negedge CLOCK);
    cmp_bit(LAD_OE_N & LDRQ_N, 1'b1);
    BUS_RESET_N = 1'b1;
    repeat (6) @(negedge CLOCK);
    cfg_base = CFG_BASE_RESET;
    cfg_rd(CFG_IDX_BASE_LO, CFG_BASE_RESET[7:0]);
    io(1'b1, 16'h027a, 8'h5a, 1'b0);
    cmp_bit(sel_q.size() == 0 && rd_q.size() == 0 && LDRQ_N === 1'b1, 1'b1);
    print_verdict();
  end
endmodule : testbench
